// file: design/supervisor_pkg.sv
// constants for the supply supervisor and watchdog
package supervisor_pkg;
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned TICK_US           = 1;
    localparam int unsigned TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned HOLD_PERIOD_MS    = 140;
    localparam int unsigned HOLD_TICKS        = HOLD_PERIOD_MS * 1000 / TICK_US;
    localparam int unsigned WD_PERIOD_MS      = 1120;
    localparam int unsigned WD_TICKS          = WD_PERIOD_MS * 1000 / TICK_US;
    localparam int unsigned MR_DELAY_US       = 5;
    localparam int unsigned MR_DELAY_CYCLES   = MR_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned MR_FILTER_CYCLES  = 100;
    localparam int unsigned STROBE_FILTER     = 2;
    localparam int unsigned LEVEL_FILTER      = 2;
    localparam int unsigned PROBE_SETTLE      = 16;
    localparam logic        MR_RST_LEVEL      = 1'b1;
    localparam logic        SUPPLY_RST_LEVEL  = 1'b1;
    localparam logic        PF_RST_LEVEL      = 1'b1;
    localparam logic        STROBE_RST_LEVEL  = 1'b0;
endpackage : supervisor_pkg

// file: design/filt_if.sv
// filtered pin level and change pulse between filter and supervisor
`timescale 1ns/1ps
`default_nettype none
interface filt_if;
    logic level;
    logic change;
    modport src (output level, output change);
    modport dst (input level, input change);
endinterface : filt_if
`default_nettype wire

// file: design/pin_filter.sv
// three-flop pin synchroniser with stable-time filter
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
    parameter int unsigned FILTER_CYCLES = 2,
    parameter logic        RST_LEVEL     = 1'b1
) (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    filt_if.src       filt
);
    localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);

    if (FILTER_CYCLES < 1) begin : g_bad_filter
        $error("pin_filter needs FILTER_CYCLES of at least 1");
    end

    logic          s1;
    logic          s2;
    logic          s3;
    logic          level;
    logic          change;
    logic [CW-1:0] cnt;
    logic          next_level;
    logic          next_change;
    logic [CW-1:0] next_cnt;

    always_comb begin
        next_level  = level;
        next_change = 1'b0;
        next_cnt    = '0;
        if ((s2 == s3) && (s3 != level)) begin
            if (cnt == CW'(FILTER_CYCLES - 1)) begin
                next_level  = s3;
                next_change = 1'b1;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1     <= RST_LEVEL;
            s2     <= RST_LEVEL;
            s3     <= RST_LEVEL;
            level  <= RST_LEVEL;
            change <= 1'b0;
            cnt    <= '0;
        end else begin
            s1     <= pin_i;
            s2     <= s1;
            s3     <= s2;
            level  <= next_level;
            change <= next_change;
            cnt    <= next_cnt;
        end
    end

    assign filt.level  = level;
    assign filt.change = change;
endmodule : pin_filter
`default_nettype wire

// file: design/supply_supervisor_watchdog.sv
// supply supervisor with manual reset, watchdog and power-fail flag
`timescale 1ns/1ps
`default_nettype none
// Contract
// - reset active while supply below trip
// - hold reset 140 ms after supply recovers
// - debounce manual reset, pulse at least 140 ms
// - manual hold period starts on release
// - manual press asserts reset within 5 us
// - no strobe edge for timeout forces reset
// - watchdog idle while reset active
// - strobe edge restarts watchdog from zero
// - after expiry hold, release, restart watchdog
// - probe strobe low 7/8, high 1/8
// - probing repeats until strobe externally driven
// - own probe edges count as servicing
// - reset polarity chosen per variant
module supply_supervisor_watchdog #(
    parameter logic        ACTIVE_HIGH_RESET = 1'b0,
    parameter int unsigned HOLD_TICKS_P      = supervisor_pkg::HOLD_TICKS,
    parameter int unsigned WD_TICKS_P        = supervisor_pkg::WD_TICKS
) (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic supply_low_i,
    input  wire logic manual_reset_n_i,
    input  wire logic watchdog_strobe_in_i,
    input  wire logic powerfail_sense_in_i,
    output var  logic watchdog_strobe_pull_o,
    output var  logic watchdog_strobe_pull_oe_n_o,
    output var  logic watchdog_flag_out_o,
    output var  logic powerfail_flag_out_o,
    output var  logic cpu_reset_o
);
    import supervisor_pkg::*;

    localparam int unsigned HW      = $clog2(HOLD_TICKS_P + 1);
    localparam int unsigned WW      = $clog2(WD_TICKS_P + 1);
    localparam int unsigned TW      = $clog2(TICK_CYCLES + 1);
    localparam int unsigned SW      = $clog2(PROBE_SETTLE + 1);
    localparam logic        RST_ON  = ACTIVE_HIGH_RESET;
    localparam int unsigned HIGH_AT = WD_TICKS_P - WD_TICKS_P / 8;

    if (HOLD_TICKS_P < 1 || WD_TICKS_P < 8 || MR_FILTER_CYCLES + 8 > MR_DELAY_CYCLES) begin : g_bad_cfg
        $error("supervisor timing parameters out of range");
    end

    filt_if mr_f ();
    filt_if sup_f ();
    filt_if pf_f ();
    filt_if wdi_f ();

    pin_filter #(.FILTER_CYCLES(MR_FILTER_CYCLES), .RST_LEVEL(MR_RST_LEVEL)) u_mr (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (manual_reset_n_i),
        .filt      (mr_f)
    );
    pin_filter #(.FILTER_CYCLES(LEVEL_FILTER), .RST_LEVEL(SUPPLY_RST_LEVEL)) u_sup (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (supply_low_i),
        .filt      (sup_f)
    );
    pin_filter #(.FILTER_CYCLES(LEVEL_FILTER), .RST_LEVEL(PF_RST_LEVEL)) u_pf (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (powerfail_sense_in_i),
        .filt      (pf_f)
    );
    pin_filter #(.FILTER_CYCLES(STROBE_FILTER), .RST_LEVEL(STROBE_RST_LEVEL)) u_wdi (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (watchdog_strobe_in_i),
        .filt      (wdi_f)
    );

    typedef enum logic {ST_RUN, ST_HOLD} sup_state_t;

    sup_state_t    state;
    sup_state_t    next_state;
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic          tick;
    logic [HW-1:0] hold_cnt;
    logic [HW-1:0] next_hold_cnt;
    logic [WW-1:0] wd_cnt;
    logic [WW-1:0] next_wd_cnt;
    logic          expire;
    logic          cause;
    logic          rst_active;
    logic          next_wd_flag;
    logic          probing;
    logic          next_probing;
    logic          probe_high;
    logic [SW-1:0] settle;
    logic [SW-1:0] next_settle;

    // microsecond timebase, restarted while a reset cause stands so no hold is short
    always_comb begin
        tick          = (tick_cnt == TW'(TICK_CYCLES - 1));
        next_tick_cnt = (tick || cause) ? '0 : tick_cnt + TW'(1);
    end

    always_comb begin
        rst_active    = (state == ST_HOLD);
        expire        = !rst_active && tick && (wd_cnt == WW'(WD_TICKS_P - 1));
        cause         = sup_f.level || !mr_f.level || expire;
        next_state    = state;
        next_hold_cnt = hold_cnt;
        if (cause) begin
            next_state    = ST_HOLD;
            next_hold_cnt = '0;
        end else if (rst_active && tick) begin
            if (hold_cnt == HW'(HOLD_TICKS_P - 1)) begin
                next_state    = ST_RUN;
                next_hold_cnt = '0;
            end else begin
                next_hold_cnt = hold_cnt + HW'(1);
            end
        end
    end

    // watchdog count, probing of an undriven strobe
    always_comb begin
        next_wd_cnt = wd_cnt;
        if (rst_active || wdi_f.change) begin
            next_wd_cnt = '0;
        end else if (tick) begin
            next_wd_cnt = expire ? '0 : wd_cnt + WW'(1);
        end
        probe_high   = (wd_cnt >= WW'(HIGH_AT));
        next_settle  = (probe_high != watchdog_strobe_pull_o) ? '0 :
                       (settle == SW'(PROBE_SETTLE)) ? settle : settle + SW'(1);
        next_probing = probing;
        if (settle == SW'(PROBE_SETTLE) && wdi_f.level != watchdog_strobe_pull_o) begin
            next_probing = 1'b0;
        end
        next_wd_flag = watchdog_flag_out_o;
        if (expire) begin
            next_wd_flag = 1'b0;
        end else if (wdi_f.change) begin
            next_wd_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state                       <= ST_HOLD;
            tick_cnt                    <= '0;
            hold_cnt                    <= '0;
            wd_cnt                      <= '0;
            probing                     <= 1'b1;
            settle                      <= '0;
            watchdog_strobe_pull_o      <= 1'b0;
            watchdog_strobe_pull_oe_n_o <= 1'b0;
            watchdog_flag_out_o         <= 1'b1;
            powerfail_flag_out_o        <= 1'b1;
            cpu_reset_o                 <= RST_ON;
        end else begin
            state                       <= next_state;
            tick_cnt                    <= next_tick_cnt;
            hold_cnt                    <= next_hold_cnt;
            wd_cnt                      <= next_wd_cnt;
            probing                     <= next_probing;
            settle                      <= next_settle;
            watchdog_strobe_pull_o      <= probe_high;
            watchdog_strobe_pull_oe_n_o <= !next_probing;
            watchdog_flag_out_o         <= next_wd_flag;
            powerfail_flag_out_o        <= !pf_f.level;
            cpu_reset_o                 <= (next_state == ST_HOLD) ? RST_ON : !RST_ON;
        end
    end

    // helper: cycles the manual reset pin has stood low
    localparam int unsigned MW = $clog2(MR_DELAY_CYCLES + 2);
    logic [MW-1:0] mr_low_run;
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mr_low_run <= '0;
        end else if (manual_reset_n_i) begin
            mr_low_run <= '0;
        end else if (mr_low_run != MW'(MR_DELAY_CYCLES)) begin
            mr_low_run <= mr_low_run + MW'(1);
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    chk_supply_holds: assert property (sup_f.level |=> cpu_reset_o == RST_ON)
        else $error("reset not active during low supply");
    chk_mr_delay: assert property (mr_low_run == MW'(MR_DELAY_CYCLES) |-> cpu_reset_o == RST_ON)
        else $error("manual reset not seen within 5 us");
    chk_hold_length: assert property ($fell(rst_active) |-> $past(tick) && $past(hold_cnt) == HW'(HOLD_TICKS_P - 1))
        else $error("reset released before hold period");
    chk_mr_hold_start: assert property (!mr_f.level |=> hold_cnt == '0 && rst_active)
        else $error("hold count advanced while manual reset low");
    chk_wd_frozen: assert property (rst_active |=> wd_cnt == '0)
        else $error("watchdog counted during reset");
    chk_wd_restart: assert property (wdi_f.change |=> wd_cnt == '0)
        else $error("strobe edge did not restart watchdog");
    chk_wd_expiry: assert property (expire |=> rst_active ##0 !watchdog_flag_out_o ##0 cpu_reset_o == RST_ON)
        else $error("expiry did not force reset and flag");
    chk_wd_flag_back: assert property (!watchdog_flag_out_o && wdi_f.change && !expire |=> watchdog_flag_out_o)
        else $error("watchdog flag not restored by strobe edge");
    chk_pf_follow: assert property (pf_f.level |=> !powerfail_flag_out_o)
        else $error("power-fail flag not low");
    chk_probe_phase: assert property (probe_high |=> watchdog_strobe_pull_o)
        else $error("probe not pulling high in last eighth");

    cov_manual: cover property (!mr_f.level ##1 mr_f.level);
    cov_expire: cover property (expire);
    cov_probe_high: cover property (probing && probe_high);
    cov_release: cover property ($fell(rst_active));
endmodule : supply_supervisor_watchdog
`default_nettype wire

// file: test/strobe_driver_model.sv
// processor model: watchdog strobe driver and reset receiver
`timescale 1ns/1ps
`default_nettype none
module strobe_driver_model (
    input  wire logic mclk_i,
    input  wire logic cpu_reset_n_i,
    input  wire logic pull_i,
    input  wire logic pull_oe_n_i,
    input  wire logic float_i,
    input  wire integer gap_i,
    output var  logic strobe_o
);
    logic drv = 1'b0;
    logic last = 1'b0;
    int   cnt = 0;
    // processor runs only out of reset, idles low and pulses high to service
    // a shortened gap starts the next pulse at once, so no edge is ever skipped
    always @(posedge mclk_i) begin
        last <= strobe_o;
        cnt  <= cnt + 1;
        if (!cpu_reset_n_i || gap_i == 0) begin
            cnt <= 0;
            drv <= 1'b0;
        end else if (drv && cnt >= 9) begin
            drv <= 1'b0;
            cnt <= 0;
        end else if (!drv && cnt >= gap_i) begin
            drv <= 1'b1;
            cnt <= 0;
        end
    end
    // floating driver: weak pull decides, else a level that keeps moving
    always_comb begin
        if (!float_i) strobe_o = drv;
        else if (!pull_oe_n_i) strobe_o = pull_i;
        else strobe_o = ~last;
    end
endmodule : strobe_driver_model
`default_nettype wire

// file: test/tb.sv
// testbench for the supply supervisor and watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
    import supervisor_pkg::*;
    typedef struct {logic lvl; int lo; int hi;} note_t;
    logic  mclk, sys_rst, supply_low, mr_n, pf_sense, strobe, pull, oe_n;
    logic  flag, pf_flag, cpu_rst, cpu_rst_hi, float_en, rst_seen;
    int    gap, cyc, mismatches, tests_run, seed, last_edge, prev_rise, rises;
    note_t notes[$];
    supply_supervisor_watchdog #(.HOLD_TICKS_P(20), .WD_TICKS_P(64)) dut (
        .mclk_i(mclk), .sys_rst_i(sys_rst), .supply_low_i(supply_low), .manual_reset_n_i(mr_n),
        .watchdog_strobe_in_i(strobe), .powerfail_sense_in_i(pf_sense), .watchdog_strobe_pull_o(pull),
        .watchdog_strobe_pull_oe_n_o(oe_n), .watchdog_flag_out_o(flag), .powerfail_flag_out_o(pf_flag),
        .cpu_reset_o(cpu_rst));
    supply_supervisor_watchdog #(.ACTIVE_HIGH_RESET(1'b1), .HOLD_TICKS_P(20), .WD_TICKS_P(64)) dut_hi (
        .mclk_i(mclk), .sys_rst_i(sys_rst), .supply_low_i(supply_low), .manual_reset_n_i(mr_n),
        .watchdog_strobe_in_i(strobe), .powerfail_sense_in_i(pf_sense), .watchdog_strobe_pull_o(),
        .watchdog_strobe_pull_oe_n_o(), .watchdog_flag_out_o(), .powerfail_flag_out_o(),
        .cpu_reset_o(cpu_rst_hi));
    strobe_driver_model cpu (.mclk_i(mclk), .cpu_reset_n_i(cpu_rst), .pull_i(pull), .pull_oe_n_i(oe_n),
        .float_i(float_en), .gap_i(gap), .strobe_o(strobe));
    task automatic report_and_stop;
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic fail(input string msg);
        mismatches++;
        $display("ERROR %0t: %s", $time, msg);
    endtask : fail
    task automatic check_bit(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) fail(msg);
    endtask : check_bit
    task automatic check_rst(input logic lvl);
        note_t n;
        tests_run++;
        if (notes.size() == 0) fail("reset output moved unexpectedly");
        else begin
            n = notes.pop_front();
            if (lvl !== n.lvl || cyc < n.lo || cyc > n.hi) fail("reset output at wrong level or time");
        end
    endtask : check_rst
    task automatic expect_rst(input logic lvl, input int base, input int lo, input int hi);
        notes.push_back('{lvl, base + lo, base + hi});
    endtask : expect_rst
    task automatic wait_rst(input logic lvl, input int max);
        for (int i = 0; i < max && cpu_rst !== lvl; i++) @(negedge mclk);
        if (cpu_rst !== lvl) fail("reset output never moved");
    endtask : wait_rst
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fail("run took too long");
            report_and_stop();
        end
    end
    always @(negedge mclk) begin
        if (cyc > 16 && cpu_rst !== rst_seen) check_rst(cpu_rst);
        rst_seen = cpu_rst;
    end
    always @(negedge mclk) if (!sys_rst) check_bit(cpu_rst_hi === ~cpu_rst, "reset variants disagree");
    always @(strobe) last_edge = cyc;
    always @(posedge pull) begin
        if (float_en && prev_rise > 0) begin
            check_bit(cyc - prev_rise >= 5550 && cyc - prev_rise <= 5800, "probe period off");
            rises++;
        end
        prev_rise = float_en ? cyc : 0;
    end
    initial begin
        seed = 32'h979d;
        {cyc, mismatches, tests_run, prev_rise, rises, last_edge} = '0;
        {supply_low, pf_sense, float_en} = '0;
        {sys_rst, mr_n} = 2'h3;
        gap = 1500;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        expect_rst(1'b1, cyc, 2000, 2200);
        wait_rst(1'b1, 2500);
        repeat (8) begin
            pf_sense = 1'($random(seed));
            repeat (10) @(negedge mclk);
            check_bit(pf_flag === ~pf_sense, "power-fail flag wrong");
        end
        supply_low = 1'b1;
        expect_rst(1'b0, cyc, 1, 10);
        repeat (300) @(negedge mclk);
        supply_low = 1'b0;
        expect_rst(1'b1, cyc, 2000, 2200);
        wait_rst(1'b1, 2500);
        mr_n = 1'b0;
        repeat (50) @(negedge mclk);
        mr_n = 1'b1;
        repeat (300) @(negedge mclk);
        mr_n = 1'b0;
        expect_rst(1'b0, cyc, 100, 500);
        repeat (900) @(negedge mclk);
        mr_n = 1'b1;
        expect_rst(1'b1, cyc, 2000, 2400);
        wait_rst(1'b1, 2600);
        repeat (4) begin
            gap = 500 + ($unsigned($random(seed)) % 4096);
            repeat (6000) @(negedge mclk);
        end
        gap = 0;
        repeat (20) @(negedge mclk);
        expect_rst(1'b0, last_edge, 6300, 6700);
        wait_rst(1'b0, 7000);
        repeat (2) @(negedge mclk);
        check_bit(flag === 1'b0, "watchdog flag not low on expiry");
        expect_rst(1'b1, cyc, 1990, 2200);
        wait_rst(1'b1, 2400);
        expect_rst(1'b0, cyc, 6300, 6700);
        wait_rst(1'b0, 7000);
        expect_rst(1'b1, cyc, 1990, 2200);
        wait_rst(1'b1, 2400);
        check_bit(oe_n === 1'b1, "probing kept on a driven pin");
        gap = 800;
        repeat (1200) @(negedge mclk);
        check_bit(flag === 1'b1, "watchdog flag not restored");
        expect_rst(1'b0, cyc, 0, 2);
        float_en = 1'b1;
        sys_rst = 1'b1;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        expect_rst(1'b1, cyc, 2000, 2200);
        wait_rst(1'b1, 2500);
        check_bit(oe_n === 1'b0, "pin not probed while open");
        repeat (20000) @(negedge mclk);
        check_bit(rises >= 2, "probing did not repeat");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
